// ===== include/aner_pkg.sv
// Package for the auto-negotiation expansion and next-page register bank
package aner_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [4:0] ADDR_EXPANSION = 5'h06;
  localparam logic [4:0] ADDR_NP_TX = 5'h07;
  localparam logic [15:0] RESET_EXPANSION = 16'h0004;
  localparam logic [15:0] RESET_NP_TX = 16'h2001;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int EXP_PAR_FAULT = 4;
  localparam int EXP_PARTNER_NP = 3;
  localparam int EXP_LOCAL_NP = 2;
  localparam int EXP_PAGE_RX = 1;
  localparam int EXP_PARTNER_AN = 0;
  localparam int EXP_RSV_LSB = 5;
  localparam int NP_MORE = 15;
  localparam int NP_RSV = 14;
  localparam int NP_FORMATTED = 13;
  localparam int NP_COMPLIANCE_ACKNOWLEDGE = 12;
  localparam int NP_TOGGLE = 11;
  localparam int NP_CODE_MSB = 10;
  localparam int BASE_TOGGLE_SRC = 11;

  // Management access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } aner_req_type;

  // Events from the negotiation logic
  typedef struct packed {
    logic par_fault;
    logic partner_np;
    logic page_rx;
    logic partner_an;
    logic page_sent;
    logic np_start;
  } aner_evt_type;

endpackage

// ===== hw/aner_latch.sv
// Latching-high status bit with read clear
`timescale 1ns/10ps

module aner_latch (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic event_in,
  input wire logic read_clr,
  output logic bit_q
);

  // Set wins over the read clear so no event is lost
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bit_q <= 1'b0;
    end else if (ce) begin
      if (event_in) begin
        bit_q <= 1'b1;
      end else if (read_clr) begin
        bit_q <= 1'b0;
      end
    end
  end

endmodule

// ===== hw/aner_regs.sv
// Expansion status and next-page transmit management registers
`timescale 1ns/10ps

module aner_regs (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire aner_pkg::aner_req_type req,
  input wire logic override_en,
  input wire logic [15:0] base_word,
  input wire aner_pkg::aner_evt_type evt,
  output logic [15:0] rdata_q,
  output logic [15:0] np_word,
  output logic last_page
);

  // ********************************************************************
  // Decode
  // ********************************************************************
  logic rd_exp;
  logic wr_exp;
  logic wr_np;
  logic par_fault_q;
  logic page_rx_q;
  logic partner_np_q;
  logic partner_an_q;
  logic [15:aner_pkg::EXP_RSV_LSB] exp_rsv_q;
  logic [15:0] np_q;
  logic toggle_q;
  logic [15:0] exp_view;
  logic rd_take;
  logic wr_exp_take;

  // ********************************************************************
  // Elaboration checks
  // ********************************************************************
  // The bit map lives in the package; refuse a map in which the reserved field,
  // the code field or the next-page flags share a bit, since the read view would then silently hide one
  if (aner_pkg::EXP_RSV_LSB <= aner_pkg::EXP_PAR_FAULT) begin : g_chk_rsv
    $error("expansion reserved field overlaps the status bits");
  end
  if (aner_pkg::NP_CODE_MSB >= aner_pkg::NP_TOGGLE) begin : g_chk_code
    $error("code field overlaps the toggle bit");
  end
  if (aner_pkg::NP_MORE >= $bits(np_q)) begin : g_chk_more
    $error("more-pages flag lies outside the register");
  end
  // Flag order from the top of the word down to the toggle
  if (!(aner_pkg::NP_MORE > aner_pkg::NP_RSV &&
        aner_pkg::NP_RSV > aner_pkg::NP_FORMATTED &&
        aner_pkg::NP_FORMATTED > aner_pkg::NP_COMPLIANCE_ACKNOWLEDGE &&
        aner_pkg::NP_COMPLIANCE_ACKNOWLEDGE > aner_pkg::NP_TOGGLE)) begin : g_chk_order
    $error("next-page flag positions out of order");
  end
  if (aner_pkg::ADDR_EXPANSION == aner_pkg::ADDR_NP_TX) begin : g_chk_addr
    $error("both registers decode at one address");
  end
  if (aner_pkg::BASE_TOGGLE_SRC >= $bits(base_word)) begin : g_chk_base
    $error("toggle seed bit lies outside the base word");
  end
  // The local next-page bit is a constant one, so its reset must agree
  if (!aner_pkg::RESET_EXPANSION[aner_pkg::EXP_LOCAL_NP]) begin : g_chk_lnp
    $error("expansion reset must show the local next-page bit");
  end
  // Toggle and the reserved bit are not stored, so their reset is zero
  if (aner_pkg::RESET_NP_TX[aner_pkg::NP_TOGGLE] ||
      aner_pkg::RESET_NP_TX[aner_pkg::NP_RSV]) begin : g_chk_nprst
    $error("next-page reset sets a bit that is not stored");
  end

  // ********************************************************************
  // Qualified strobes
  // ********************************************************************
  // Only an enabled edge takes a request; with ce low nothing moves,
  // not even the side effect of a read
  assign rd_take = ce && req.rd;
  // Reserved writes pass only while the override is set
  assign wr_exp_take = ce && wr_exp && override_en;

  // Same-clock requests, one cycle each
  assign rd_exp = req.rd && (req.addr == aner_pkg::ADDR_EXPANSION);
  assign wr_exp = req.wr && (req.addr == aner_pkg::ADDR_EXPANSION);
  assign wr_np = req.wr && (req.addr == aner_pkg::ADDR_NP_TX);

  // ********************************************************************
  // Latching status bits
  // ********************************************************************
  aner_latch u_par_fault (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .event_in(evt.par_fault),
    .read_clr(rd_exp),
    .bit_q(par_fault_q)
  );

  aner_latch u_page_rx (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .event_in(evt.page_rx),
    .read_clr(rd_exp),
    .bit_q(page_rx_q)
  );

  // Partner capability levels
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      partner_np_q <= 1'b0;
      partner_an_q <= 1'b0;
    end else if (ce) begin
      partner_np_q <= evt.partner_np;
      partner_an_q <= evt.partner_an;
    end
  end

  // ********************************************************************
  // Override-gated reserved bits
  // ********************************************************************
  // One flop per reserved bit; each keeps what the last permitted write
  // left. None reaches the read view, so reads of them stay zero, and
  // software cannot see whether an override write landed
  for (genvar i = aner_pkg::EXP_RSV_LSB; i < $bits(exp_view);
       i++) begin : g_rsv
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        exp_rsv_q[i] <= 1'b0;
      end else if (wr_exp_take) begin
        exp_rsv_q[i] <= req.wdata[i];
      end
    end
  end

  // ********************************************************************
  // Next-page transmit register
  // ********************************************************************
  // Reserved bit 14 and toggle are not writable
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      np_q <= aner_pkg::RESET_NP_TX;
    end else if (ce && wr_np) begin
      np_q[aner_pkg::NP_MORE] <= req.wdata[aner_pkg::NP_MORE];
      np_q[aner_pkg::NP_FORMATTED] <= req.wdata[aner_pkg::NP_FORMATTED];
      np_q[aner_pkg::NP_COMPLIANCE_ACKNOWLEDGE] <= req.wdata[aner_pkg::NP_COMPLIANCE_ACKNOWLEDGE];
      np_q[aner_pkg::NP_CODE_MSB:0] <= req.wdata[aner_pkg::NP_CODE_MSB:0];
    end
  end

  // Toggle: seeded at page start, flips per sent page
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      toggle_q <= 1'b0;
    end else if (ce) begin
      if (evt.np_start) begin
        toggle_q <= ~base_word[aner_pkg::BASE_TOGGLE_SRC];
      end else if (evt.page_sent) begin
        toggle_q <= ~toggle_q;
      end
    end
  end

  // Transmitted code word
  always_comb begin
    np_word = np_q;
    np_word[aner_pkg::NP_RSV] = 1'b0;
    np_word[aner_pkg::NP_TOGGLE] = toggle_q;
  end
  assign last_page = ~np_q[aner_pkg::NP_MORE];

  // ********************************************************************
  // Read data
  // ********************************************************************
  // Expansion view, built apart from the flop so that an event in the
  // read cycle still shows: the latch keeps it too, so it is never lost
  always_comb begin
    exp_view = '0;
    exp_view[aner_pkg::EXP_PAR_FAULT] = par_fault_q | evt.par_fault;
    exp_view[aner_pkg::EXP_PARTNER_NP] = partner_np_q;
    exp_view[aner_pkg::EXP_LOCAL_NP] = 1'b1;
    exp_view[aner_pkg::EXP_PAGE_RX] = page_rx_q | evt.page_rx;
    exp_view[aner_pkg::EXP_PARTNER_AN] = partner_an_q;
  end

  // Registered read data; it stands until the next read is taken
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= '0;
    end else if (rd_take) begin
      if (rd_exp) begin
        rdata_q <= exp_view;
      end else if (req.addr == aner_pkg::ADDR_NP_TX) begin
        rdata_q <= np_word;
      end else begin
        rdata_q <= '0; // Unmapped
      end
    end
  end

endmodule

// ===== tb/aner_sta.sv
// Station management model issuing single-cycle register requests
`timescale 1ns/10ps
module aner_sta (
  input wire logic mclk,
  output aner_pkg::aner_req_type req
);
  // *****
  // Access launcher
  // *****
  initial req = '0;
  // Held over one rising edge, then released to idle
  task automatic acc(input logic w, input logic [4:0] a,
                     input logic [15:0] d);
    @(negedge mclk);
    req = {~w, w, a, d};
    @(negedge mclk);
    req = '0;
  endtask
endmodule

// ===== tb/aner_assertions.sv
// Checker for the expansion and next-page register bank
`timescale 1ns/10ps
module aner_chk (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire aner_pkg::aner_req_type req,
  input wire logic [15:0] base_word,
  input wire aner_pkg::aner_evt_type evt,
  input wire logic [15:0] rdata_q,
  input wire logic [15:0] np_word,
  input wire logic last_page
);
  // Expansion read taken this edge
  logic r6;
  assign r6 = ce && req.rd && req.addr == aner_pkg::ADDR_EXPANSION;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Event, then a read one edge later
  sequence s_pr;
    ce && evt.page_rx ##1 r6;
  endsequence
  // Fault pulse, then a read one edge later
  sequence s_pf;
    ce && evt.par_fault ##1 r6;
  endsequence
  // Read, a quiet cycle, then a second read with no new page
  sequence s_clr;
    r6 && !evt.page_rx ##1 !evt.page_rx ##1 r6 && !evt.page_rx;
  endsequence
  a_rsv_zero: assert property (r6 |=> rdata_q[15:5] == 0)
    else $error("reserved read nonzero");
  a_local_np: assert property (r6 |=> rdata_q[2])
    else $error("local bit low");
  a_page_latch: assert property (s_pr |=> rdata_q[1])
    else $error("page bit lost");
  a_fault_latch: assert property (s_pf |=> rdata_q[4])
    else $error("fault bit lost");
  a_page_clear: assert property (s_clr |=> !rdata_q[1])
    else $error("page bit kept");
  a_partner_np: assert property (ce && evt.partner_np ##1
    r6 && evt.partner_np |=> rdata_q[3]) else $error("partner bit low");
  a_np_write: assert property (ce && req.wr && req.addr == 5'h07 |=>
    (np_word & 16'hf7ff) == ($past(req.wdata) & 16'hb7ff)) else $error("np word");
  a_toggle_seed: assert property (ce && evt.np_start |=>
    np_word[11] == !$past(base_word[11])) else $error("toggle seed");
  a_last_page: assert property (last_page == !np_word[15])
    else $error("last page flag");
endmodule

// ===== tb/tb.sv
// Top testbench for the expansion and next-page registers
`timescale 1ns/10ps
module tb;
  logic mclk = 0, resetn = 0, ce = 1, override_en = 0, last_page;
  logic [15:0] base_word = 0, rdata_q, np_word;
  aner_pkg::aner_evt_type evt = '0;
  aner_pkg::aner_req_type req;
  int bad_count = 0, checks_done = 0, cyc = 0;
  aner_sta i_aner_sta (.mclk(mclk), .req(req));
  aner_regs i_aner_regs (.*);
  always #25 mclk = ~mclk;
  // *****
  // Helpers
  // *****
  task automatic chk(input logic [15:0] s, e, input string n);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s exp %h saw %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    i_aner_sta.acc(0, a, 0);
    chk(rdata_q, e, "rdata");
  endtask
  // One-cycle event pulse; levels drop with it
  task automatic ev(input aner_pkg::aner_evt_type v);
    @(negedge mclk);
    evt = v;
    @(negedge mclk);
    evt = '0;
  endtask
  task automatic give_verdict();
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard, the run needs well under 100 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 500) begin
      bad_count++;
      give_verdict();
    end
  end
  // *****
  // Tests
  // *****
  initial begin
    repeat (4) @(negedge mclk);
    resetn = 1;
    chk(np_word, 16'h2001, "np");
    rd(6, 16'h0004);
    i_aner_sta.acc(1, 6, 16'hffff);
    override_en = 1;
    i_aner_sta.acc(1, 6, 16'hffe4);
    rd(6, 16'h0004);
    $display("t1 done");
    ev(6'b101000);
    rd(6, 16'h0016);
    rd(6, 16'h0004);
    evt = 6'b010100;
    rd(6, 16'h000d);
    evt = '0;
    rd(6, 16'h0004);
    $display("t2 done");
    i_aner_sta.acc(1, 7, 16'hffff);
    rd(7, 16'hb7ff);
    chk({15'h0, last_page}, 16'h0000, "last");
    ev(6'b000001);
    chk(np_word, 16'hbfff, "np");
    ev(6'b000010);
    chk(np_word, 16'hb7ff, "np");
    i_aner_sta.acc(1, 7, 16'h2005);
    chk(np_word, 16'h2005, "np");
    chk({15'h0, last_page}, 16'h0001, "last");
    $display("t3 done");
    ce = 0;
    ev(6'b001000);
    ce = 1;
    rd(6, 16'h0004);
    rd(5'h1f, 16'h0000);
    $display("t4 done");
    give_verdict();
  end
endmodule
bind aner_regs aner_chk i_aner_chk (.*);
